// [hdl/acl_match_pkg.sv]
// Types for the IPv4 entry matcher.
// Assumes the constants header is included by users of field positions.
package acl_match_pkg;

  typedef enum logic [1:0] {FT_ANY, FT_IPV4, FT_OTHER, FT_RSVD} frame_type_t;
  typedef enum logic [2:0] {
    PR_ANY, PR_SPECIFIC, PR_ICMP, PR_UDP, PR_TCP, PR_R5, PR_R6, PR_R7
  } proto_sel_t;
  // Zero / non-zero / any style three-way setting
  typedef enum logic [1:0] {TRI_NO, TRI_YES, TRI_ANY, TRI_RSVD} tri_sel_t;
  typedef enum logic [1:0] {AD_ANY, AD_HOST, AD_NET, AD_RSVD} addr_sel_t;

  // Header fields from the frame parser
  typedef struct packed {
    logic is_ipv4;
    logic [7:0] protocol;
    logic [7:0] ttl;
    logic more_fragments_flag;
    logic [12:0] fragment_offset_field;
    logic has_options;
    logic [31:0] source_ipv4_address;
    logic [31:0] destination_ipv4_address;
  } ipv4_hdr_t;

  // Sub-condition results from the layer-4 matchers
  typedef struct packed {
    logic icmp_ok;
    logic udp_ok;
    logic tcp_ok;
  } l4_result_t;

endpackage : acl_match_pkg

// [hdl/acl_match_regs.svh]
// Register map, field layouts, reset values and encodings for the matcher.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
// Operation
// - IPv4 conditions apply only when the entry's frame type selects IPv4.
// - Protocol selector any ignores the protocol field.
// - Selector specific needs protocol equal to stored value, 0..255.
// - Selector ICMP needs ICMP frames plus the ICMP sub-condition result.
// - Selector UDP needs UDP frames plus the UDP port sub-condition result.
// - Selector TCP needs TCP frames plus the TCP sub-condition result.
// - TTL setting zero refuses frames whose TTL is above zero.
// - TTL setting non-zero lets frames with TTL above zero match.
// - TTL setting any disregards the TTL field.
// - Fragmented means more-fragments set or fragment offset nonzero.
// - Fragment no rejects fragmented frames; any ignores fragmentation.
// - Fragment yes lets fragmented frames match.
// - Options no rejects frames with options; any ignores options.
// - Options yes lets frames with options match.
// - Source selector any skips the source address compare.
// - Source selector host needs exact source address equality.
// - Source selector network compares source under the source mask.
// - Destination selector any skips the destination address compare.
// - Destination selector host needs exact destination address equality.
// - Destination selector network compares under the destination mask.
`ifndef ACL_MATCH_REGS_SVH
`define ACL_MATCH_REGS_SVH

// Byte offsets
`define OFS_CTRL 4'h0
`define OFS_SRC_ADDR 4'h4
`define OFS_SRC_MASK 4'h8
`define OFS_DST_ADDR 4'hC
`define OFS_STATUS 5'h10
`define OFS_COUNT 5'h14

// Control field positions
`define CTRL_FTYPE_LSB 0
`define CTRL_PROTO_LSB 2
`define CTRL_TTL_LSB 5
`define CTRL_FRAG_LSB 7
`define CTRL_OPT_LSB 9
`define CTRL_SRC_LSB 11
`define CTRL_DST_LSB 13
`define CTRL_PVAL_LSB 16
`define CTRL_DST_MASK_LSB 24

// Reset values
`define CTRL_RESET 32'h0000_0000
`define MASK_RESET 32'hFFFF_FFFF

// Protocol numbers carried in the header
`define PROTO_ICMP 8'h01
`define PROTO_TCP 8'h06
`define PROTO_UDP 8'h11

`endif

// [hdl/ipv4_acl_header_matcher.sv]
// IPv4 header matcher for one access_control_entry, with Avalon-MM
// registers holding the entry settings and a hit counter.
// Assumes a parser on the same clock giving a one-cycle valid strobe.
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "acl_match_regs.svh"

module ipv4_acl_header_matcher
  import acl_match_pkg::*;
#(
  parameter int COUNT_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // Frame parser side
  input wire logic hdr_valid,
  input wire ipv4_hdr_t hdr,
  input wire l4_result_t l4,
  // Decision
  output logic result_valid,
  output logic entry_hit
);

  // Byte-lane merge used by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Masked address compare shared by both address filters
  function automatic logic addr_ok(input addr_sel_t sel,
                                   input logic [31:0] frame_a,
                                   input logic [31:0] stored_a,
                                   input logic [31:0] mask);
    logic ok;
    case (sel)
      AD_ANY: ok = 1'b1;
      AD_HOST: ok = (frame_a == stored_a);
      AD_NET: ok = ((frame_a & mask) == (stored_a & mask));
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : addr_ok

  // Three-way setting: no rejects the condition, yes requires it
  function automatic logic tri_ok(input tri_sel_t sel, input logic cond);
    logic ok;
    case (sel)
      TRI_NO: ok = !cond;
      TRI_YES: ok = cond;
      TRI_ANY: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : tri_ok

  // Register map, all words 32 bits wide:
  //   0x00 control, read/write
  //     [1:0]   frame type: any, IPv4, other, reserved
  //     [4:2]   protocol selector: any, specific, ICMP, UDP, TCP
  //     [6:5]   time-to-live: zero, non-zero, any
  //     [8:7]   fragment: no, yes, any
  //     [10:9]  options: no, yes, any
  //     [12:11] source selector: any, host, network
  //     [14:13] destination selector: any, host, network
  //     [23:16] protocol value for the specific selector
  //     [29:24] destination prefix length, 32 and above is all ones
  //   0x04 source address, read/write
  //   0x08 source mask, read/write, all ones after reset
  //   0x0C destination address, read/write
  //   0x10 status of the last strobe, read only
  //     [7] seen, [6] protocol, [5] time-to-live, [4] fragment,
  //     [3] options, [2] source, [1] destination, [0] hit
  //   0x14 hit count, read only, saturating, a write clears it unless a hit lands in the same cycle
  //
  // Reserved selector codes make their condition fail, so a half
  // written control word can never widen what the entry accepts.
  //
  // Bus timing: the first cycle of every access raises waitrequest,
  // the second lowers it. Writes land at that second edge, the one
  // at which the master sees waitrequest low, so a master that drops
  // its request early never leaves a half-written register behind.
  // Read data is captured in the first cycle and stands until the
  // next access, so it is settled long before the master takes it.
  //
  // Decision timing: the header and layer-4 results are sampled at
  // the strobe edge; the result strobe and the hit level follow one
  // cycle later. The hit level stands until the next strobe.
  //
  // Limitation: the destination mask is a prefix length only, so a
  // non-contiguous destination mask cannot be expressed. The source
  // mask is a full word and may hold any pattern.
  //
  // Storage for the entry settings and bus response
  logic [31:0] ctrl_q;
  logic [31:0] src_addr_q;
  logic [31:0] src_mask_q;
  logic [31:0] dst_addr_q;
  logic [COUNT_W-1:0] hit_count_q;
  logic [31:0] status_q;
  logic bus_ack_q;
  logic [31:0] readdata_q;
  logic [1:0] response_q;
  logic result_valid_q;
  logic entry_hit_q;

  // Destination mask is a prefix length in the top control byte,
  // trading a spare register slot for a contiguous-only mask.
  logic [5:0] dst_plen;
  logic [31:0] dst_mask;
  assign dst_plen = ctrl_q[`CTRL_DST_MASK_LSB +: 6];
  assign dst_mask = (dst_plen >= 6'd32) ? 32'hFFFF_FFFF :
                    ~(32'hFFFF_FFFF >> dst_plen[4:0]);

  // Decoded entry settings
  frame_type_t ftype;
  proto_sel_t psel;
  tri_sel_t ttl_sel;
  tri_sel_t frag_sel;
  tri_sel_t opt_sel;
  addr_sel_t src_sel;
  addr_sel_t dst_sel;
  logic [7:0] proto_val;
  assign ftype = frame_type_t'(ctrl_q[`CTRL_FTYPE_LSB +: 2]);
  assign psel = proto_sel_t'(ctrl_q[`CTRL_PROTO_LSB +: 3]);
  assign ttl_sel = tri_sel_t'(ctrl_q[`CTRL_TTL_LSB +: 2]);
  assign frag_sel = tri_sel_t'(ctrl_q[`CTRL_FRAG_LSB +: 2]);
  assign opt_sel = tri_sel_t'(ctrl_q[`CTRL_OPT_LSB +: 2]);
  assign src_sel = addr_sel_t'(ctrl_q[`CTRL_SRC_LSB +: 2]);
  assign dst_sel = addr_sel_t'(ctrl_q[`CTRL_DST_LSB +: 2]);
  assign proto_val = ctrl_q[`CTRL_PVAL_LSB +: 8];

  // Protocol condition
  logic proto_ok;
  always_comb begin
    case (psel)
      PR_ANY: proto_ok = 1'b1;
      PR_SPECIFIC: proto_ok = (hdr.protocol == proto_val);
      PR_ICMP: proto_ok = (hdr.protocol == `PROTO_ICMP) && l4.icmp_ok;
      PR_UDP: proto_ok = (hdr.protocol == `PROTO_UDP) && l4.udp_ok;
      PR_TCP: proto_ok = (hdr.protocol == `PROTO_TCP) && l4.tcp_ok;
      default: proto_ok = 1'b0;
    endcase
  end

  // Header conditions; TTL no means zero, yes means non-zero
  logic ttl_ok;
  logic fragmented;
  logic frag_ok;
  logic opt_ok;
  logic src_ok;
  logic dst_ok;
  assign ttl_ok = tri_ok(ttl_sel, hdr.ttl != 8'h00);
  assign fragmented = hdr.more_fragments_flag ||
                      (hdr.fragment_offset_field != 13'h0000);
  assign frag_ok = tri_ok(frag_sel, fragmented);
  assign opt_ok = tri_ok(opt_sel, hdr.has_options);
  assign src_ok = addr_ok(src_sel, hdr.source_ipv4_address,
                          src_addr_q, src_mask_q);
  assign dst_ok = addr_ok(dst_sel, hdr.destination_ipv4_address,
                          dst_addr_q, dst_mask);

  // Entry hit: all conditions at once, IPv4 entries on IPv4 frames only
  logic hit_now;
  assign hit_now = (ftype == FT_IPV4) && hdr.is_ipv4 &&
                   proto_ok && ttl_ok && frag_ok && opt_ok &&
                   src_ok && dst_ok;

  // Decision register, one result per parser strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      result_valid_q <= 1'b0;
      entry_hit_q <= 1'b0;
    end else begin
      result_valid_q <= hdr_valid;
      if (hdr_valid) begin
        entry_hit_q <= hit_now;
      end
    end
  end

  // Hit counter and last-decision status; saturates rather than wraps
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hit_count_q <= '0;
      status_q <= 32'h0000_0000;
    end else begin
      // A hit and a clear in one cycle: the hit wins, even saturated
      if (hdr_valid && hit_now) begin
        if (!(&hit_count_q)) begin
          hit_count_q <= hit_count_q + 1'b1;
        end
      end else if (bus_ack_q && write &&
                   address == `OFS_COUNT) begin
        hit_count_q <= '0;
      end
      if (hdr_valid) begin
        status_q <= {24'h00_0000, 1'b1, proto_ok, ttl_ok, frag_ok,
                     opt_ok, src_ok, dst_ok, hit_now};
      end
    end
  end

  // Bus handshake: every access answers one cycle after it is seen
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_ack_q <= 1'b0;
    end else begin
      bus_ack_q <= (read || write) && !bus_ack_q;
    end
  end
  assign waitrequest = (read || write) && !bus_ack_q;

  // Register writes land at the edge where waitrequest is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= `CTRL_RESET;
      src_addr_q <= 32'h0000_0000;
      src_mask_q <= `MASK_RESET;
      dst_addr_q <= 32'h0000_0000;
    end else if (write && bus_ack_q) begin
      case (address)
        5'(`OFS_CTRL): ctrl_q <= merge(ctrl_q, writedata, byteenable);
        5'(`OFS_SRC_ADDR): begin
          src_addr_q <= merge(src_addr_q, writedata, byteenable);
        end
        5'(`OFS_SRC_MASK): begin
          src_mask_q <= merge(src_mask_q, writedata, byteenable);
        end
        5'(`OFS_DST_ADDR): begin
          dst_addr_q <= merge(dst_addr_q, writedata, byteenable);
        end
        default: ;
      endcase
    end
  end

  // Read data and response, captured when the access is first seen
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readdata_q <= 32'h0000_0000;
      response_q <= 2'h0;
    end else if ((read || write) && !bus_ack_q) begin
      response_q <= 2'h0;
      readdata_q <= 32'h0000_0000;
      case (address)
        5'(`OFS_CTRL): readdata_q <= ctrl_q;
        5'(`OFS_SRC_ADDR): readdata_q <= src_addr_q;
        5'(`OFS_SRC_MASK): readdata_q <= src_mask_q;
        5'(`OFS_DST_ADDR): readdata_q <= dst_addr_q;
        `OFS_STATUS: readdata_q <= status_q;
        `OFS_COUNT: readdata_q <= 32'(hit_count_q);
        default: response_q <= 2'h2;  // Unmapped: slave error
      endcase
    end
  end

  assign readdata = readdata_q;
  assign response = response_q;
  assign result_valid = result_valid_q;
  assign entry_hit = entry_hit_q;

endmodule : ipv4_acl_header_matcher
`default_nettype wire

// [tb/acl_hdr_chk.sv]
// Checker for the IPv4 entry matcher, bound to its top module.
// Assumes full-word writes to the control register.
`timescale 1ns/100ps
`default_nettype none
module acl_hdr_chk
  import acl_match_pkg::*;
(
  // Clock, reset and register bus
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] response,
  // Parser side and decision
  input wire logic hdr_valid,
  input wire ipv4_hdr_t hdr,
  input wire l4_result_t l4,
  input wire logic result_valid,
  input wire logic entry_hit
);
  logic [31:0] ctrl_q;
  // Shadow of the settings; write lands where waitrequest is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      ctrl_q <= 32'h0;
    else if (write && !waitrequest && address == 5'h00 &&
             byteenable == 4'hF)
      ctrl_q <= writedata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_PULSE: assert property (result_valid == $past(hdr_valid))
    else $error("result strobe not one cycle after header");
  AST_HOLD: assert property (!result_valid |-> $stable(entry_hit))
    else $error("hit changed without result strobe");
  AST_ANY: assert property (hdr_valid && hdr.is_ipv4 &&
    ctrl_q[14:0] == 15'h0541 |=> entry_hit) else $error("all-any missed");
  AST_FTYPE: assert property (hdr_valid && (!hdr.is_ipv4 ||
    ctrl_q[1:0] == 2'h2) |=> !entry_hit) else $error("type hit");
  AST_PVAL: assert property (hdr_valid && ctrl_q[4:2] == 3'h1 &&
    hdr.protocol != ctrl_q[23:16] |=> !entry_hit) else $error("pval hit");
  AST_ICMP: assert property (hdr_valid && ctrl_q[4:2] == 3'h2 &&
    !(l4.icmp_ok && hdr.protocol == 8'h01) ##1 1'b1 |-> !entry_hit)
    else $error("icmp hit");
  AST_TTL: assert property (hdr_valid && ctrl_q[6:5] == 2'h0 &&
    hdr.ttl != 8'h00 |=> !entry_hit) else $error("ttl hit");
  AST_FRAG: assert property (hdr_valid && ctrl_q[8:7] == 2'h0 &&
    (hdr.more_fragments_flag || hdr.fragment_offset_field != 13'h0000)
    |=> !entry_hit) else $error("fragment hit");
  AST_OPT: assert property (hdr_valid && ctrl_q[10:9] == 2'h0 &&
    hdr.has_options |=> !entry_hit) else $error("options hit");
  // Main scenarios reached
  cover property (hdr_valid ##1 entry_hit);
  cover property (result_valid && !entry_hit);
  cover property (write && address == 5'h08);
endmodule : acl_hdr_chk
bind ipv4_acl_header_matcher acl_hdr_chk chk (.clk, .reset, .address,
  .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
  .response, .hdr_valid, .hdr, .l4, .result_valid, .entry_hit);
`default_nettype wire

// [tb/hdr_parser_model.sv]
// Model of the upstream frame parser feeding header fields.
// Assumes the caller enters send away from a clock edge.
`timescale 1ns/100ps
`default_nettype none
module hdr_parser_model
  import acl_match_pkg::*;
(
  // Clock
  input wire logic clk,
  // Header toward the matcher
  output logic hdr_valid,
  output ipv4_hdr_t hdr,
  output l4_result_t l4
);
  initial begin
    hdr_valid = 1'b0;
    hdr = '0;
    l4 = '0;
  end
  // One-cycle strobe; fields inverted after so stale data cannot match
  task automatic send(input ipv4_hdr_t h, input l4_result_t r);
    @(posedge clk);
    hdr_valid <= 1'b1;
    hdr <= h;
    l4 <= r;
    @(posedge clk);
    hdr_valid <= 1'b0;
    hdr <= ~h;
    l4 <= ~r;
  endtask : send
endmodule : hdr_parser_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the IPv4 entry matcher.
// Assumes one wait state per access and result one cycle after strobe.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import acl_match_pkg::*;
  localparam logic [31:0] BASE = 32'h0000_0541;
  logic clk, reset, read, write, waitrequest, hdr_valid, result_valid;
  logic entry_hit;
  logic [4:0] address;
  logic [31:0] writedata, readdata, rd_q;
  logic [3:0] byteenable;
  logic [1:0] response, rsp_q;
  ipv4_hdr_t hdr, b;
  l4_result_t l4;
  int fails, checked;
  ipv4_acl_header_matcher dut (.clk, .reset, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .response,
    .hdr_valid, .hdr, .l4, .result_valid, .entry_hit);
  hdr_parser_model pm (.clk, .hdr_valid, .hdr, .l4);
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d);
    @(posedge clk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd_q = readdata;
    rsp_q = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic go(input logic [31:0] c, input ipv4_hdr_t h,
      input l4_result_t r, input logic e);
    bus(1'b1, 5'h00, c);
    pm.send(h, r);
    #1;
    cmp({31'h0, result_valid}, 32'h1);
    cmp({31'h0, entry_hit}, {31'h0, e});
  endtask : go
  task automatic t_regs;
    bus(1'b0, 5'h08, 32'h0);
    cmp(rd_q, 32'hFFFF_FFFF);
    bus(1'b0, 5'h18, 32'h0);
    cmp({30'h0, rsp_q}, 32'h2);
    bus(1'b1, 5'h04, 32'h1234_5678);
    bus(1'b0, 5'h04, 32'h0);
    cmp(rd_q, 32'h1234_5678);
  endtask : t_regs
  task automatic t_ftype;
    ipv4_hdr_t h;
    h = b;
    h.is_ipv4 = 1'b0;
    go(BASE, b, 3'h0, 1'b1);
    go(BASE ^ 32'h3, b, 3'h0, 1'b0);
    go(BASE, h, 3'h0, 1'b0);
    bus(1'b0, 5'h14, 32'h0);
    cmp(rd_q, 32'h1);
    bus(1'b0, 5'h10, 32'h0);
    cmp(rd_q, 32'hFE);
    bus(1'b1, 5'h14, 32'h0);
    bus(1'b0, 5'h14, 32'h0);
    cmp(rd_q, 32'h0);
  endtask : t_ftype
  task automatic t_proto;
    ipv4_hdr_t h;
    logic [7:0] pn [3] = '{8'h01, 8'h11, 8'h06};
    h = b;
    go(BASE | 32'h0006_0004, b, 3'h0, 1'b1);
    go(BASE | 32'h0007_0004, b, 3'h0, 1'b0);
    h.protocol = 8'h00;
    go(BASE | 32'h0000_0004, h, 3'h0, 1'b1);
    h.protocol = 8'hFF;
    go(BASE | 32'h00FF_0004, h, 3'h0, 1'b1);
    go(BASE, h, 3'h0, 1'b1);
    // Right protocol, missing sub-condition, wrong protocol
    for (int k = 0; k < 3; k++) begin
      h.protocol = pn[k];
      go(BASE | ((k + 2) << 2), h, 3'h7, 1'b1);
      go(BASE | ((k + 2) << 2), h, 3'h7 ^ (3'h4 >> k), 1'b0);
      h.protocol = pn[(k + 1) % 3];
      go(BASE | ((k + 2) << 2), h, 3'h7, 1'b0);
    end
  endtask : t_proto
  // TTL, fragment, options: each setting against both frame kinds
  task automatic t_tri;
    ipv4_hdr_t h;
    for (int f = 0; f < 3; f++)
      for (int s = 0; s < 3; s++)
        for (int v = 0; v < 2; v++) begin
          h = b;
          if (f == 0)
            h.ttl = v ? 8'h05 : 8'h00;
          if (f == 1)
            h.more_fragments_flag = v && s != 1;
          if (f == 1)
            h.fragment_offset_field = (v && s == 1) ? 13'h0001 : 13'h0000;
          if (f == 2)
            h.has_options = v[0];
          go(BASE & ~(32'h3 << (5 + 2 * f)) | (s << (5 + 2 * f)), h, 3'h7,
            s == 2 || (s == 1) == v);
        end
  endtask : t_tri
  // Low-bit and high-bit mismatches under a /24 mask
  task automatic t_addr;
    ipv4_hdr_t h;
    logic [31:0] fl;
    logic [31:0] c;
    logic e;
    bus(1'b1, 5'h04, 32'h0A00_0001);
    bus(1'b1, 5'h08, 32'hFFFF_FF00);
    bus(1'b1, 5'h0C, 32'hC0A8_0102);
    for (int d = 0; d < 2; d++)
      for (int s = 0; s < 3; s++)
        for (int m = 0; m < 3; m++) begin
          h = b;
          fl = m == 0 ? 32'h0 : (m == 1 ? 32'h1 : 32'h8000_0000);
          if (d == 0)
            h.source_ipv4_address ^= fl;
          else
            h.destination_ipv4_address ^= fl;
          c = BASE | 32'h1800_0000 | (s << (11 + 2 * d));
          e = s == 0 || m == 0 || (s == 2 && m == 1);
          go(c, h, 3'h7, e);
        end
  endtask : t_addr
  task automatic results;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #(40 * 3000);
    fails++;
    results;
  end
  initial begin
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'hF;
    b = '0;
    b.is_ipv4 = 1'b1;
    b.protocol = 8'h06;
    b.ttl = 8'h05;
    b.source_ipv4_address = 32'h0A00_0001;
    b.destination_ipv4_address = 32'hC0A8_0102;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_ftype;
    t_proto;
    t_tri;
    t_addr;
    results;
  end
endmodule : testbench
`default_nettype wire
